// file: src/quad_dac_pkg.sv
// Purpose: shared constants and state types for the quad converter link
// Assumes: one 20 MHz clock, two-wire link sampled synchronously
// Notes: both ends import this whole package
//
// What this block does
// [R01] mode 00 writes only selected staging register
// [R02] mode 00 leaves every output register alone
// [R03] mode 01 writes staging and selected output
// [R04] mode 10 writes selected, loads all outputs
// [R05] mode 11 pick low: outputs take staging
// [R06] mode 11 pick high: all outputs take data
// [R07] mode 11 pick high powerdown: all powered down
// [R08] master zeroes two top bits unless broadcast; bit 3 ignored
// [R09] powerdown flag: high byte top bits are code
// [R10] high byte holds upper eight code bits
// [R11] low byte bits 7,6 hold lowest code bits
// [R12] update at falling edge ending low-byte acknowledge
// [R13] readback registers cleared to zero at reset
// [R14] per-channel 12-bit staging register, code plus powerdown
// [R15] per-channel 12-bit output register, immediate effect
// [R16] full command byte latched for following bytes
// [R17] slave receiver with 7-bit bus address
// [R18] data pairs repeat until stop or start
// [R19] powerdown frame carries exactly two data bytes
// [R20] reset clears staging and output registers
package quad_dac_pkg;

	localparam int CLK_HZ = 20_000_000;
	localparam int LINK_KHZ = 100;
	// four quarter phases make one link bit
	localparam int QUARTERS_PER_BIT = 4;
	localparam int QUARTER_CYCLES = CLK_HZ / (LINK_KHZ * 1000 * QUARTERS_PER_BIT);

	localparam int CHANNELS = 4;
	localparam int CODE_W = 10;
	localparam int WORD_W = 12;
	localparam logic [WORD_W-1:0] ZERO_WORD = 12'h000;

	// bus address: fixed prefix plus two strap bits
	localparam logic [4:0] ADDR_PREFIX = 5'h13;
	// arbitrary value for the all-devices address
	localparam logic [6:0] BROADCAST_ADDR = 7'h48;

	// command byte field positions
	localparam int CMD_TOP_HI = 7;
	localparam int CMD_TOP_LO = 6;
	localparam int UPDATE_MODE_HI = 5;
	localparam int UPDATE_MODE_LO = 4;
	localparam int CHANNEL_PICK_HI = 2;
	localparam int CHANNEL_PICK_LO = 1;
	localparam int POWERDOWN_FLAG = 0;

	// high byte powerdown code, low byte code bits
	localparam int POWERDOWN_CODE_HI = 7;
	localparam int POWERDOWN_CODE_LO = 6;
	localparam int LOW_CODE_HI = 7;
	localparam int LOW_CODE_LO = 6;

	localparam logic [1:0] MODE_STAGE = 2'h0;
	localparam logic [1:0] MODE_LOAD_ONE = 2'h1;
	localparam logic [1:0] MODE_LOAD_ALL = 2'h2;
	localparam logic [1:0] MODE_BROADCAST = 2'h3;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [2:0] FRAME_BYTES = 3'h4;
	localparam logic [2:0] PAIR_BYTES = 3'h2;

	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_ADDR = 6'h02,
		S_CMD = 6'h04,
		S_HIGH = 6'h08,
		S_LOW = 6'h10,
		S_DONE = 6'h20
	} dev_state_type;

	typedef enum logic [4:0] {
		M_IDLE = 5'h01,
		M_START = 5'h02,
		M_BIT = 5'h04,
		M_STOP = 5'h08,
		M_WAIT = 5'h10
	} host_state_type;

endpackage

// file: src/quad_dac_link_if.sv
// Purpose: two-wire link between host end and converter end
// Assumes: open-drain data resolved here, clock driven by host only
// Notes: enables high while an end pulls data low
interface quad_dac_link_if;
	logic scl;
	logic sda_host_out;
	logic sda_host_oe;
	logic sda_dev_out;
	logic sda_dev_oe;
	logic sda;

	// wired-and of both drivers, released wire reads high
	assign sda = (~sda_host_oe | sda_host_out) & (~sda_dev_oe | sda_dev_out);

	modport host (
		output scl,
		output sda_host_out,
		output sda_host_oe,
		input sda
	);
	modport device (
		input scl,
		input sda,
		output sda_dev_out,
		output sda_dev_oe
	);
endinterface

// file: src/quad_dac_host.sv
// Purpose: link master that sends address, command and data pairs
// Assumes: one request per pair, first one of a frame carries addr/cmd
// Notes: a refused acknowledge ends the frame with a stop
module quad_dac_host
	import quad_dac_pkg::*;
#(
	parameter int QUARTER = QUARTER_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset,
	quad_dac_link_if.host link,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [6:0] req_addr,
	input wire logic [7:0] req_cmd,
	input wire logic [7:0] req_high,
	input wire logic [7:0] req_low,
	input wire logic req_last,
	output logic busy,
	output logic nack_flag
);
	// tick counter is 16 bits wide, so longer quarters cannot be counted
	if (QUARTER < 2 || QUARTER > 65536) begin : g_check
		$error("quarter period must be 2 to 65536 cycles");
	end

	host_state_type state, next_state;
	logic [15:0] tick_cnt, next_tick_cnt;
	logic [1:0] quarter, next_quarter;
	logic [3:0] bitn, next_bitn;
	logic [2:0] bytes, next_bytes;
	logic [31:0] sh, next_sh;
	logic last_q, next_last_q;
	logic scl_high, next_scl_high;
	logic sda_low, next_sda_low;
	logic next_nack;
	logic tick, accept, mode_bcast;
	logic [7:0] cmd_fixed;

	assign link.scl = scl_high;
	assign link.sda_host_out = 1'b0;
	assign link.sda_host_oe = sda_low;
	assign req_ready = (state == M_IDLE) || (state == M_WAIT);
	assign busy = (state != M_IDLE);
	assign accept = req_valid & req_ready;
	assign tick = (tick_cnt == 16'(QUARTER - 1));
	assign mode_bcast =
		(req_cmd[UPDATE_MODE_HI:UPDATE_MODE_LO] == MODE_BROADCAST);
	// top bits forced low unless broadcast
	assign cmd_fixed = mode_bcast ? req_cmd
		: {2'h0, req_cmd[CMD_TOP_LO-1:0]}; // R08

	// frame sequencing in quarter-bit steps
	always_comb begin
		next_state = state;
		next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
		next_quarter = quarter;
		next_bitn = bitn;
		next_bytes = bytes;
		next_sh = sh;
		next_last_q = last_q;
		next_scl_high = scl_high;
		next_sda_low = sda_low;
		next_nack = nack_flag;
		if (accept && state == M_IDLE) begin
			next_sh = {req_addr, 1'b0, cmd_fixed, req_high, req_low}; // R17
			next_bytes = FRAME_BYTES;
			// powerdown frame holds exactly one pair
			next_last_q = req_last | req_cmd[POWERDOWN_FLAG]; // R19
			next_nack = 1'b0;
			next_state = M_START;
			next_quarter = 2'h0;
			next_tick_cnt = 16'h0000;
		end else if (accept) begin
			next_sh = {req_high, req_low, 16'h0000}; // R18
			next_bytes = PAIR_BYTES;
			next_last_q = req_last;
			next_state = M_BIT;
			next_bitn = 4'h0;
			next_quarter = 2'h0;
			next_tick_cnt = 16'h0000;
		end else if (tick && state != M_IDLE && state != M_WAIT) begin
			next_quarter = quarter + 2'h1;
			case (state)
				M_START: begin
					if (quarter == 2'h1) next_sda_low = 1'b1;
					if (quarter == 2'h2) next_scl_high = 1'b0;
					if (quarter == 2'h3) begin
						next_state = M_BIT;
						next_bitn = 4'h0;
					end
				end
				M_BIT: begin
					if (quarter == 2'h0)
						next_sda_low = (bitn == BITS_PER_BYTE) ? 1'b0 : ~sh[31];
					if (quarter == 2'h1) next_scl_high = 1'b1;
					if (quarter == 2'h2 && bitn == BITS_PER_BYTE)
						next_nack = nack_flag | link.sda;
					if (quarter == 2'h3) begin
						next_scl_high = 1'b0;
						if (bitn != BITS_PER_BYTE) begin
							next_sh = {sh[30:0], 1'b0};
							next_bitn = bitn + 4'h1;
						end else begin
							next_bitn = 4'h0;
							next_bytes = bytes - 3'h1;
							if (nack_flag)
								next_state = M_STOP;
							else if (bytes == 3'h1)
								next_state = last_q ? M_STOP : M_WAIT;
						end
					end
				end
				M_STOP: begin
					if (quarter == 2'h0) next_sda_low = 1'b1;
					if (quarter == 2'h1) next_scl_high = 1'b1;
					if (quarter == 2'h2) next_sda_low = 1'b0;
					if (quarter == 2'h3) next_state = M_IDLE;
				end
				default: next_state = M_IDLE;
			endcase
		end
	end

	// register stage, wire idles released
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= M_IDLE;
			tick_cnt <= 16'h0000;
			quarter <= 2'h0;
			bitn <= 4'h0;
			bytes <= 3'h0;
			sh <= 32'h0000_0000;
			last_q <= 1'b0;
			scl_high <= 1'b1;
			sda_low <= 1'b0;
			nack_flag <= 1'b0;
		end else begin
			state <= next_state;
			tick_cnt <= next_tick_cnt;
			quarter <= next_quarter;
			bitn <= next_bitn;
			bytes <= next_bytes;
			sh <= next_sh;
			last_q <= next_last_q;
			scl_high <= next_scl_high;
			sda_low <= next_sda_low;
			nack_flag <= next_nack;
		end
	end
endmodule

// file: src/quad_dac_device.sv
// Purpose: converter end, decodes command and routes data bytes
// Assumes: link pins synchronous to clk_sys, host owns the clock wire
// Notes: output registers feed the analog channels directly
module quad_dac_device
	import quad_dac_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	quad_dac_link_if.device link,
	input wire logic [1:0] addr_pins,
	output logic [CHANNELS-1:0][WORD_W-1:0] output_channel,
	output logic [CHANNELS-1:0][WORD_W-1:0] staging_register,
	output logic [7:0] command_byte_reg,
	output logic [7:0] high_data_byte_reg,
	output logic [7:0] low_data_byte_reg,
	output logic update_pulse
);
	dev_state_type state, next_state;
	logic scl_q, sda_q;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic ack_phase, next_ack_phase;
	logic ack_drive, next_ack_drive;
	logic [7:0] shift, next_shift;
	logic bcast_hit, next_bcast_hit;
	logic [7:0] next_command, next_high, next_low;
	logic next_update;

	logic scl_rise, scl_fall, start_seen, stop_seen;
	logic own_hit, all_hit, addr_match, byte_acked, apply;
	logic [1:0] mode, pick;
	logic pick_hi, pd_flag, act;
	logic [WORD_W-1:0] word;
	logic [WORD_W-1:0] next_stage [CHANNELS];
	logic [WORD_W-1:0] next_out [CHANNELS];

	// data wire only ever pulled low by this end
	assign link.sda_dev_out = 1'b0;
	assign link.sda_dev_oe = ack_drive;

	// link events from one registered sample
	assign scl_rise = link.scl & ~scl_q;
	assign scl_fall = ~link.scl & scl_q;
	assign start_seen = link.scl & scl_q & sda_q & ~link.sda;
	assign stop_seen = link.scl & scl_q & ~sda_q & link.sda;

	// write address: own prefix plus straps, or all-devices
	assign own_hit = (shift[7:1] == {ADDR_PREFIX, addr_pins}); // R17
	assign all_hit = (shift[7:1] == BROADCAST_ADDR);
	assign addr_match = ~shift[0] & (own_hit | all_hit);

	// command fields, bit 3 and top bits never looked at
	assign mode = command_byte_reg[UPDATE_MODE_HI:UPDATE_MODE_LO]; // R08
	assign pick = command_byte_reg[CHANNEL_PICK_HI:CHANNEL_PICK_LO];
	assign pick_hi = command_byte_reg[CHANNEL_PICK_HI];
	assign pd_flag = command_byte_reg[POWERDOWN_FLAG];

	// which bytes get an acknowledge
	always_comb begin
		case (state)
			S_ADDR: byte_acked = addr_match;
			S_CMD: byte_acked = 1'b1;
			S_HIGH: byte_acked = 1'b1;
			S_LOW: byte_acked = 1'b1;
			default: byte_acked = 1'b0;
		endcase
	end

	// update fires when the low-byte acknowledge clock falls
	assign apply = (state == S_LOW) & scl_fall & ack_phase
		& (bit_cnt == BITS_PER_BYTE) & ~stop_seen & ~start_seen; // R12

	// all-devices address only acts in the broadcast mode
	assign act = apply & (~bcast_hit | (mode == MODE_BROADCAST));

	// new 12-bit word: powerdown code on top, or plain code
	always_comb begin
		if (pd_flag) begin
			word = {high_data_byte_reg[POWERDOWN_CODE_HI:POWERDOWN_CODE_LO],
				CODE_W'(0)}; // R09
		end else begin
			word = {2'h0, high_data_byte_reg,
				shift[LOW_CODE_HI:LOW_CODE_LO]}; // R10 R11
		end
	end

	// per-channel staging and output update
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
		logic sel_hit;
		assign sel_hit = (pick == 2'(ch)); // R01
		always_comb begin
			next_stage[ch] = staging_register[ch];
			next_out[ch] = output_channel[ch];
			if (act) begin
				case (mode)
					MODE_STAGE: begin
						// output holds its previous level
						if (sel_hit) next_stage[ch] = word; // R01 R02
					end
					MODE_LOAD_ONE: begin
						if (sel_hit) begin
							next_stage[ch] = word; // R03
							next_out[ch] = word; // R03 R15
						end
					end
					MODE_LOAD_ALL: begin
						if (sel_hit) next_stage[ch] = word; // R04
						// selected takes new word, rest their staging
						next_out[ch] = sel_hit ? word
							: staging_register[ch]; // R04
					end
					MODE_BROADCAST: begin
						// staging untouched by broadcast updates
						next_out[ch] = pick_hi ? word
							: staging_register[ch]; // R05 R06 R07
					end
					default: next_out[ch] = output_channel[ch];
				endcase
			end
		end
	end

	// byte framing, acknowledge and byte routing
	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_ack_phase = ack_phase;
		next_ack_drive = ack_drive;
		next_shift = shift;
		next_bcast_hit = bcast_hit;
		next_command = command_byte_reg;
		next_high = high_data_byte_reg;
		next_low = low_data_byte_reg;
		next_update = 1'b0;
		if (stop_seen) begin
			// a stop ends any run of data pairs
			next_state = S_IDLE; // R18
			next_bit_cnt = 4'h0;
			next_ack_phase = 1'b0;
			next_ack_drive = 1'b0;
		end else if (start_seen) begin
			// repeated start restarts at the address byte
			next_state = S_ADDR; // R18
			next_bit_cnt = 4'h0;
			next_ack_phase = 1'b0;
			next_ack_drive = 1'b0;
		end else if (state != S_IDLE) begin
			if (scl_rise && bit_cnt < BITS_PER_BYTE) begin
				next_shift = {shift[6:0], link.sda};
				next_bit_cnt = bit_cnt + 4'h1;
			end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
				if (!ack_phase) begin
					// pull the wire low for the ninth clock when byte_acked is set
					next_ack_phase = 1'b1;
					next_ack_drive = byte_acked;
				end else begin
					next_ack_phase = 1'b0;
					next_ack_drive = 1'b0;
					next_bit_cnt = 4'h0;
					case (state)
						S_ADDR: begin
							next_state = addr_match ? S_CMD : S_IDLE;
							next_bcast_hit = all_hit;
						end
						S_CMD: begin
							next_command = shift; // R16
							next_state = S_HIGH;
						end
						S_HIGH: begin
							next_high = shift;
							next_state = S_LOW;
						end
						S_LOW: begin
							next_low = shift;
							next_update = act & (mode != MODE_STAGE);
							// powerdown frames take no further pair
							next_state = pd_flag ? S_DONE : S_HIGH; // R19 R18
						end
						default: next_state = S_DONE;
					endcase
				end
			end
		end
	end

	// registers; reset brings every channel to zero
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= S_IDLE;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			bit_cnt <= 4'h0;
			ack_phase <= 1'b0;
			ack_drive <= 1'b0;
			shift <= 8'h00;
			bcast_hit <= 1'b0;
			command_byte_reg <= 8'h00;
			high_data_byte_reg <= 8'h00;
			low_data_byte_reg <= 8'h00;
			update_pulse <= 1'b0;
			for (int i = 0; i < CHANNELS; i++) begin
				staging_register[i] <= ZERO_WORD; // R13 R14 R20
				output_channel[i] <= ZERO_WORD; // R15 R20
			end
		end else begin
			state <= next_state;
			scl_q <= link.scl;
			sda_q <= link.sda;
			bit_cnt <= next_bit_cnt;
			ack_phase <= next_ack_phase;
			ack_drive <= next_ack_drive;
			shift <= next_shift;
			bcast_hit <= next_bcast_hit;
			command_byte_reg <= next_command;
			high_data_byte_reg <= next_high;
			low_data_byte_reg <= next_low;
			update_pulse <= next_update;
			for (int i = 0; i < CHANNELS; i++) begin
				staging_register[i] <= next_stage[i];
				output_channel[i] <= next_out[i];
			end
		end
	end
endmodule

// file: verification/quad_dac_chk.sv
// Purpose: wire checks on the link between both ends
// Assumes: one clk_sys, reset synchronous active high
// Notes: fall counter restarts at each start condition
module quad_dac_chk (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_host_out,
	input wire logic sda_host_oe,
	input wire logic sda_dev_out,
	input wire logic sda_dev_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic scl_q, sda_q;
	logic [3:0] falls, next_falls;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// count scl falls; 9 means the ack slot comes next
	always_comb begin
		next_falls = falls;
		if (reset)
			next_falls = 4'h0;
		else if (scl & scl_q & sda_q & ~sda)
			next_falls = 4'h0;
		else if (scl_q & ~scl)
			next_falls = (falls == 4'h9) ? 4'h1 : falls + 4'h1;
	end
	always_ff @(posedge clk_sys) begin
		scl_q <= scl;
		sda_q <= sda;
		falls <= next_falls;
	end
	// device may only pull the wire inside the ninth slot
	ack_only_slot_a: assert property (
		sda_dev_oe |-> !sda_dev_out && falls == 4'h9)
		else $error("device drives data outside ack slot");
	host_ack_free_a: assert property (
		scl && falls == 4'h9 |-> !sda_host_oe && !sda_host_out)
		else $error("host drives data in ack clock");
	reset_idle_a: assert property ($fell(reset) |->
		scl && !sda_host_oe && !sda_dev_oe)
		else $error("link not idle after reset");
	ack_slot_a: assert property ($rose(sda_dev_oe) |-> falls == 4'h9)
		else $error("ack outside ninth bit");
	ack_hold_a: assert property ($rose(sda_dev_oe) |-> sda_dev_oe[*4])
		else $error("ack too short");
	ack_scl_low_a: assert property ($changed(sda_dev_oe) |-> !scl)
		else $error("ack changed with clock high");
	ack_release_a: assert property (
		scl_q && !scl && sda_dev_oe |-> ##[1:3] !sda_dev_oe)
		else $error("ack not released");
	start_free_a: assert property (
		scl && scl_q && sda_q && !sda |-> !sda_dev_oe)
		else $error("device holds data at start");
endmodule

// file: verification/tb_top.sv
// Purpose: drives the host end, checks converter registers
// Assumes: QUARTER cut to 3 so frames stay short
// Notes: expected words come from a local register model
module tb_top;
	import quad_dac_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [6:0] NO_ADDR = 7'h21;
	localparam int LIMIT = 9000;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic req_valid = 1'b0, req_last = 1'b0, req_ready, busy, nack_flag;
	logic [6:0] req_addr = 7'h00, own;
	logic [7:0] req_cmd = 8'h00, req_high = 8'h00, req_low = 8'h00;
	logic [7:0] cmd_seen, high_seen, low_seen;
	logic [1:0] addr_pins = 2'h0;
	logic [CHANNELS-1:0][WORD_W-1:0] output_channel, staging_register;
	logic [CHANNELS-1:0][WORD_W-1:0] stg, outp;
	logic update_pulse;
	logic [31:0] seed = 32'h0000B163;
	int error_cnt = 0, comparisons = 0;
	logic [47:0] notes[$];
	quad_dac_link_if link();

	quad_dac_host #(.QUARTER(3)) quad_dac_host_inst (.clk_sys(clk_sys),
		.reset(reset), .link(link), .req_valid(req_valid),
		.req_ready(req_ready), .req_addr(req_addr), .req_cmd(req_cmd),
		.req_high(req_high), .req_low(req_low), .req_last(req_last),
		.busy(busy), .nack_flag(nack_flag));
	quad_dac_device quad_dac_device_inst (.clk_sys(clk_sys), .reset(reset),
		.link(link), .addr_pins(addr_pins), .output_channel(output_channel),
		.staging_register(staging_register), .command_byte_reg(cmd_seen),
		.high_data_byte_reg(high_seen), .low_data_byte_reg(low_seen),
		.update_pulse(update_pulse));
	quad_dac_chk quad_dac_chk_inst (.clk_sys(clk_sys), .reset(reset),
		.scl(link.scl), .sda(link.sda), .sda_host_out(link.sda_host_out),
		.sda_host_oe(link.sda_host_oe), .sda_dev_out(link.sda_dev_out),
		.sda_dev_oe(link.sda_dev_oe));

	// 50 ns period
	always #25 clk_sys = ~clk_sys;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// a wait that runs out ends the run at once
	task automatic limit(input int k);
		if (k >= LIMIT) begin
			error_cnt++;
			$display("Error at %0t: wait ran out", $time);
			finish_test();
		end
	endtask

	// one pair; request held until ready is seen high
	task automatic send(input logic [7:0] c, h, l, input logic [6:0] a,
		input logic last);
		int k;
		@(negedge clk_sys);
		{req_valid, req_addr, req_cmd, req_high, req_low} = {1'b1, a, c, h, l};
		req_last = last;
		for (k = 0; k < LIMIT && req_ready !== 1'b1; k++)
			@(negedge clk_sys);
		limit(k);
		@(posedge clk_sys);
		@(negedge clk_sys);
		req_valid = 1'b0;
	endtask

	// frame of n pairs; the model notes every expected update
	task automatic frame(input logic [6:0] a, input logic [7:0] c, input int n);
		logic [7:0] h, l, ce;
		logic [11:0] w;
		logic hit;
		int k;
		hit = a == own || (a == BROADCAST_ADDR && c[5:4] == MODE_BROADCAST);
		for (int i = 0; i < n; i++) begin
			h = c[0] ? {2'(rnd()), 6'h00} : 8'(rnd());
			l = c[0] ? 8'h00 : 8'(rnd());
			w = c[0] ? {h[7:6], 10'h000} : {2'h0, h, l[7:6]};
			if (hit) begin
				case (c[5:4])
				MODE_STAGE: stg[c[2:1]] = w;
				MODE_LOAD_ONE: outp[c[2:1]] = w;
				MODE_LOAD_ALL: outp = stg;
				default: outp = c[2] ? {4{w}} : stg;
				endcase
				if (c[5:4] inside {MODE_LOAD_ONE, MODE_LOAD_ALL})
					stg[c[2:1]] = w;
				if (c[5:4] == MODE_LOAD_ALL)
					outp[c[2:1]] = w;
				if (c[5:4] != MODE_STAGE)
					notes.push_back(outp);
			end
			send(c, h, l, a, i == n - 1);
		end
		for (k = 0; k < LIMIT && busy !== 1'b0; k++)
			@(negedge clk_sys);
		limit(k);
		check(48'(nack_flag), 48'(a != own && a != BROADCAST_ADDR));
		check(staging_register, stg);
		check(output_channel, outp);
		check(48'(notes.size()), 48'h0);
		// top command bits reach the wire only in broadcast mode
		ce = (c[5:4] == MODE_BROADCAST) ? c : {2'h0, c[5:0]};
		if (hit) begin
			check(48'(cmd_seen), 48'(ce));
			check(48'(high_seen), 48'(h));
			check(48'(low_seen), 48'(l));
		end
	endtask

	// each update pulse takes the oldest note
	always @(negedge clk_sys) begin
		if (update_pulse === 1'b1 && notes.size() == 0)
			check(48'h1, 48'h0);
		else if (update_pulse === 1'b1)
			check(output_channel, notes.pop_front());
	end

	initial begin
		addr_pins = 2'(rnd());
		own = {ADDR_PREFIX, addr_pins};
		stg = '0;
		outp = '0;
		repeat (10) @(negedge clk_sys);
		reset = 1'b0;
		@(negedge clk_sys);
		check(staging_register, 48'h0);
		check(output_channel, 48'h0);
		$display("test reset done");
		for (int m = 0; m < 3; m++)
			for (int ch = 0; ch < 4; ch++)
				frame(own, {2'(rnd()), m[1:0], 1'(rnd()), ch[1:0], 1'b0}, 1);
		$display("test modes done");
		for (int m = 0; m < 3; m++)
			frame(own, {2'h0, m[1:0], 1'(rnd()), 2'(rnd()), 1'b1}, 1);
		$display("test powerdown done");
		for (int j = 0; j < 3; j++)
			frame(BROADCAST_ADDR, {2'(rnd()), 3'h6, j != 0, 1'(rnd()), j == 2}, 1);
		$display("test broadcast done");
		frame(own, 8'h12, 3);
		frame(NO_ADDR, 8'h10, 1);
		frame(BROADCAST_ADDR, 8'h16, 1);
		$display("test address done");
		reset = 1'b1;
		repeat (2) @(negedge clk_sys);
		reset = 1'b0;
		@(negedge clk_sys);
		check(staging_register | output_channel, 48'h0);
		$display("test second reset done");
		finish_test();
	end
endmodule
